// *** verilog/otdc_map.svh ***
// Register map, field positions, reset values and timing counts of the tap delay control.
`ifndef OTDC_MAP_SVH
`define OTDC_MAP_SVH
// Register byte offsets on the Wishbone bus.
`define OTDC_CFG_OFS        4'h0
`define OTDC_VALUE_OFS      4'h4
`define OTDC_RATIO_OFS      4'h8
`define OTDC_STATUS_OFS     4'hC
// Configuration field positions.
`define OTDC_CFG_MODE_LO    0
`define OTDC_CFG_MODE_HI    1
`define OTDC_CFG_FMT_TIME   2
`define OTDC_CFG_WIDTH8     3
`define OTDC_CFG_CLKTYPE    4
`define OTDC_CFG_POS_LO     5
`define OTDC_CFG_POS_HI     7
// Reset values.
`define OTDC_CFG_RST        32'h0000_0004
`define OTDC_VALUE_RST      32'h0000_0000
`define OTDC_RATIO_RST      32'h0000_0033
// Tap line geometry.
`define OTDC_TAP_W          9
// Timing: times in ns, clock period in ps, counts derived (least times round up).
`define OTDC_CLK_PERIOD_PS  25000
`define OTDC_DELAY_READY_NS  1000
`define OTDC_COMP_READY_NS   2000
`define OTDC_DELAY_READY_CYC \
   (((`OTDC_DELAY_READY_NS * 1000) + `OTDC_CLK_PERIOD_PS - 1) / `OTDC_CLK_PERIOD_PS)
`define OTDC_COMP_READY_CYC  \
   (((`OTDC_COMP_READY_NS * 1000) + `OTDC_CLK_PERIOD_PS - 1) / `OTDC_CLK_PERIOD_PS)
`endif

// *** verilog/otdc_pkg.sv ***
// Types shared by the output tap delay control.
package otdc_pkg;
   // Delay line operating mode.
   typedef enum logic [1:0] {
      OTDC_FIXED,
      OTDC_VARIABLE,
      OTDC_VAR_LOAD,
      OTDC_MODE_SPARE
   } otdc_mode_e;
   typedef logic [8:0] otdc_tap_t;
endpackage : otdc_pkg

// *** verilog/otdc_top.sv ***
// Output tap delay control with pad receive path and Wishbone register slave.
`timescale 1ns/100ps
`include "otdc_map.svh"

module otdc_top (
   // Clock and reset.
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   // Wishbone classic slave.
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic             wb_ack_o,
   output logic      [31:0] wb_dat_o,
   // Fabric tap control.
   input  wire logic        compensation_enable,
   input  wire logic        step_req,
   input  wire logic        step_dir,
   input  wire logic        tap_load_strobe,
   input  wire logic [8:0]  tap_load_bus,
   output logic      [8:0]  tap_readback_bus,
   output logic             delay_ready,
   output logic             compensation_ready,
   // Pad receive path.
   input  wire logic        pad_input,
   output logic      [7:0]  par_q,
   output logic             par_valid,
   output logic             strobe_fwd
);

   logic [31:0] cfg_r, value_r, ratio_r;
   logic        ack_r;
   logic [31:0] rdat_r;
   logic [8:0]  tap_r, base_r;
   logic [7:0]  cal_cnt_r;
   logic        delay_ready_r, comp_ready_r;
   logic        pad_m_r, pad_s_r;
   logic [7:0]  shift_r, q_r;
   logic [2:0]  bit_cnt_r;
   logic        valid_r, fwd_r;

   // Configuration decode.
   wire otdc_pkg::otdc_mode_e mode_w =
      otdc_pkg::otdc_mode_e'(cfg_r[`OTDC_CFG_MODE_HI:`OTDC_CFG_MODE_LO]);
   wire       fmt_time = cfg_r[`OTDC_CFG_FMT_TIME];
   wire       width8   = cfg_r[`OTDC_CFG_WIDTH8];
   wire       clk_type = cfg_r[`OTDC_CFG_CLKTYPE];
   wire [2:0] slice_pos = cfg_r[`OTDC_CFG_POS_HI:`OTDC_CFG_POS_LO];
   wire       is_fixed = (mode_w != otdc_pkg::OTDC_VARIABLE) &&
                         (mode_w != otdc_pkg::OTDC_VAR_LOAD);

   // Bus decode; unmapped offsets ack with zero data and ignore writes.
   wire        req      = wb_cyc_i & wb_stb_i & ~ack_r;
   wire        wr       = req & wb_we_i;
   wire [31:0] lane_m   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire        cfg_err  = clk_type & (slice_pos != 3'h0);
   wire [31:0] status_w = {19'h0_0000, cfg_err, comp_ready_r, delay_ready_r, 1'b0, tap_r};
   wire [31:0] rd_mux   = (wb_adr_i == `OTDC_CFG_OFS)    ? cfg_r   :
                          (wb_adr_i == `OTDC_VALUE_OFS)  ? value_r :
                          (wb_adr_i == `OTDC_RATIO_OFS)  ? ratio_r :
                          (wb_adr_i == `OTDC_STATUS_OFS) ? status_w : 32'h0000_0000;

   // Registers answer one cycle after the request is seen; ack lasts one cycle.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ack_r   <= 1'b0;
         rdat_r  <= 32'h0000_0000;
         cfg_r   <= `OTDC_CFG_RST;
         value_r <= `OTDC_VALUE_RST;
         ratio_r <= `OTDC_RATIO_RST;
      end else begin
         ack_r  <= req;
         rdat_r <= req ? rd_mux : 32'h0000_0000;
         if (wr && wb_adr_i == `OTDC_CFG_OFS) cfg_r <= (cfg_r & ~lane_m) | (wb_dat_i & lane_m);
         if (wr && wb_adr_i == `OTDC_VALUE_OFS) value_r <= (value_r & ~lane_m) | (wb_dat_i & lane_m);
         if (wr && wb_adr_i == `OTDC_RATIO_OFS) ratio_r <= (ratio_r & ~lane_m) | (wb_dat_i & lane_m);
      end
   end

   // The ratio scales picoseconds to taps for the output tap line.
   wire [31:0] ps_prod = value_r[15:0] * ratio_r[15:0];
   wire [8:0]  base_w  = fmt_time ? ps_prod[16:8] : value_r[8:0];

   // Compensation runs only in time format with the enable held high.
   wire       comp_on = fmt_time & compensation_enable & delay_ready_r;
   wire [8:0] tap_cmp = comp_on ? 9'(tap_r + base_w - base_r) : tap_r;
   wire [8:0] tap_stp = step_dir ? 9'(tap_cmp + 9'h001) : 9'(tap_cmp - 9'h001);
   wire       stp_ok  = step_req & ~is_fixed;
   wire       load_ok = tap_load_strobe & (mode_w == otdc_pkg::OTDC_VAR_LOAD);
   // A load beats a step in the same cycle; fixed mode ignores both.
   wire [8:0] tap_nxt = (~delay_ready_r || is_fixed) ? base_w :
                        load_ok ? tap_load_bus :
                        stp_ok  ? tap_stp : tap_cmp;

   // Tap state; the base follows the configured delay while compensating, before delay ready and in fixed mode.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tap_r  <= 9'h000;
         base_r <= 9'h000;
      end else begin
         tap_r <= tap_nxt;
         if (comp_on || !delay_ready_r || is_fixed) base_r <= base_w;
      end
   end

   // Calibration sequencer: delay ready after a fixed time, then compensation
   // ready once the enable has been high long enough in total; a drop pauses the count without clearing it.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cal_cnt_r <= 8'h00;
         delay_ready_r <= 1'b0;
         comp_ready_r  <= 1'b0;
      end else begin
         // One counter serves both phases, since they never overlap.
         // Compensation ready is sticky: a later drop of the enable does not clear it,
         // so fabric can run several updates without a new calibration.
         if (!delay_ready_r) begin
            cal_cnt_r <= cal_cnt_r + 8'h01;
            if (cal_cnt_r == 8'(`OTDC_DELAY_READY_CYC - 1)) begin
               delay_ready_r <= 1'b1;
               cal_cnt_r     <= 8'h00;
            end
         end else if (!comp_ready_r && compensation_enable) begin
            cal_cnt_r <= cal_cnt_r + 8'h01;
            if (cal_cnt_r == 8'(`OTDC_COMP_READY_CYC - 1)) comp_ready_r <= 1'b1;
         end
      end
   end

   // Receive path; the pad is asynchronous so it passes two flip-flops first.
   wire       q5_ok    = ~((slice_pos == 3'h0) || (slice_pos == 3'h6)) | delay_ready_r;
   wire [2:0] last_bit = width8 ? 3'h7 : 3'h3;
   wire       word_end = (bit_cnt_r == last_bit);
   wire [7:0] word_w   = {shift_r[6:0], pad_s_r};
   // Width 4 keeps the upper nibble quiet apart from the raw stream on bit 5.
   wire [7:0] q_nxt    = width8 ? (word_end ? word_w : q_r) :
                         {2'b00, pad_s_r & q5_ok, 1'b0, word_end ? word_w[3:0] : q_r[3:0]};

   // Parallel output is launched on the read clock, one word per frame.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pad_m_r   <= 1'b0;
         pad_s_r   <= 1'b0;
         shift_r   <= 8'h00;
         bit_cnt_r <= 3'h0;
         q_r       <= 8'h00;
         valid_r   <= 1'b0;
         fwd_r     <= 1'b0;
      end else begin
         pad_m_r   <= pad_input;
         pad_s_r   <= pad_m_r;
         shift_r   <= word_w;
         bit_cnt_r <= word_end ? 3'h0 : 3'(bit_cnt_r + 3'h1);
         q_r       <= q_nxt;
         valid_r   <= word_end;
         fwd_r     <= clk_type & (slice_pos == 3'h0) & pad_s_r;
      end
   end

   // Outputs straight from flip-flops.
   assign wb_ack_o           = ack_r;
   assign wb_dat_o           = rdat_r;
   assign tap_readback_bus   = tap_r;
   assign delay_ready        = delay_ready_r;
   assign compensation_ready = comp_ready_r;
   assign par_q              = q_r;
   assign par_valid          = valid_r;
   assign strobe_fwd         = fwd_r;

   // Checks on the tap engine, calibration, receive path and bus.
   a_fixed_tap_cfg: assert property (@(posedge sys_clk) disable iff (sys_rst)
      is_fixed && delay_ready_r |=> tap_r == $past(base_w))
      else $error("Fixed mode tap left the configured value.");
   // Count format takes the value as a raw tap count, independent of the ratio.
   a_count_raw_taps: assert property (@(posedge sys_clk) disable iff (sys_rst)
      is_fixed && !fmt_time && delay_ready_r |=> tap_r == $past(value_r[8:0]))
      else $error("Count format tap differs from the configured value.");
   a_step_up_wrap: assert property (@(posedge sys_clk) disable iff (sys_rst)
      delay_ready_r && !comp_on && mode_w == otdc_pkg::OTDC_VARIABLE && step_req && step_dir
      |=> tap_r == 9'($past(tap_r) + 9'h001))
      else $error("Step up did not add exactly one tap.");
   // A step down removes exactly one tap.
   a_step_down: assert property (@(posedge sys_clk) disable iff (sys_rst)
      delay_ready_r && !comp_on && mode_w == otdc_pkg::OTDC_VARIABLE && step_req && !step_dir
      |=> tap_r == 9'($past(tap_r) - 9'h001))
      else $error("Step down did not remove exactly one tap.");
   a_step_dn_wrap: assert property (@(posedge sys_clk) disable iff (sys_rst)
      delay_ready_r && !comp_on && !is_fixed && !load_ok && step_req && !step_dir
      && tap_r == 9'h000
      |=> tap_r == 9'h1FF)
      else $error("Step down from zero did not wrap to the top tap.");
   a_load_wins: assert property (@(posedge sys_clk) disable iff (sys_rst)
      delay_ready_r && mode_w == otdc_pkg::OTDC_VAR_LOAD && tap_load_strobe && step_req
      |=> tap_r == $past(tap_load_bus))
      else $error("Load did not override a same-cycle step.");
   // Load mode takes the presented tap value one cycle after the strobe.
   a_load_taken: assert property (@(posedge sys_clk) disable iff (sys_rst)
      delay_ready_r && mode_w == otdc_pkg::OTDC_VAR_LOAD && tap_load_strobe
      |=> tap_r == $past(tap_load_bus))
      else $error("Load mode did not take the presented tap.");
   // Variable mode must ignore a load strobe.
   a_var_no_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
      delay_ready_r && !comp_on && mode_w == otdc_pkg::OTDC_VARIABLE && tap_load_strobe
      && !step_req |=> $stable(tap_r))
      else $error("Variable mode accepted a load.");
   a_count_no_comp: assert property (@(posedge sys_clk) disable iff (sys_rst)
      delay_ready_r && !fmt_time && !is_fixed && !step_req && !tap_load_strobe
      |=> $stable(tap_r))
      else $error("Count format tap moved without a command.");
   a_time_comp_track: assert property (@(posedge sys_clk) disable iff (sys_rst)
      comp_on && !is_fixed && !step_req && !tap_load_strobe
      |=> tap_r == 9'($past(tap_r) + $past(base_w) - $past(base_r)))
      else $error("Compensation did not track the base delay.");
   a_q5_gated: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !width8 && slice_pos == 3'h6 && !delay_ready_r |=> !par_q[5])
      else $error("Raw stream visible before delay ready.");
   // Once delay ready, width 4 shows the synchronised pad level on bit 5.
   a_w4_raw_bit: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !width8 && delay_ready_r |=> par_q[5] == $past(pad_s_r))
      else $error("Raw stream missing on bit 5 in width 4.");
   a_w4_upper_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !width8 |=> par_q[7:6] == 2'b00 && !par_q[4])
      else $error("Unused parallel bits driven in width 4.");
   a_w8_word: assert property (@(posedge sys_clk) disable iff (sys_rst)
      width8 && word_end |=> par_valid && par_q == $past(word_w))
      else $error("Width 8 word not delivered.");
   // A new word is flagged for a single read clock cycle.
   a_valid_pulse: assert property (@(posedge sys_clk) disable iff (sys_rst)
      par_valid |=> !par_valid)
      else $error("Word flag lasted more than one cycle.");
   // A misplaced clock slice must never forward its pad.
   a_no_fwd_misplaced: assert property (@(posedge sys_clk) disable iff (sys_rst)
      clk_type && slice_pos != 3'h0 |=> !strobe_fwd)
      else $error("Strobe forwarded from a misplaced slice.");
   a_strobe_pos: assert property (@(posedge sys_clk) disable iff (sys_rst)
      strobe_fwd |-> $past(slice_pos) == 3'h0)
      else $error("Strobe forwarded from a nonzero position.");
   a_ready_order: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(compensation_ready) |-> delay_ready && $past(compensation_enable))
      else $error("Compensation ready came before delay ready.");
   a_bus_ack: assert property (@(posedge sys_clk) disable iff (sys_rst)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("Bus ack not a single cycle after request.");
   // Read data stays quiet outside an acknowledged cycle.
   a_idle_read_data: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("Read data driven without an ack.");

   // Main scenarios that the bench is expected to reach.

   c_var_step:  cover property (@(posedge sys_clk) disable iff (sys_rst)
      mode_w == otdc_pkg::OTDC_VARIABLE && stp_ok ##1 stp_ok);
   c_load:      cover property (@(posedge sys_clk) disable iff (sys_rst) load_ok);
   c_comp_move: cover property (@(posedge sys_clk) disable iff (sys_rst)
      comp_on && base_w != base_r);
   c_word8:     cover property (@(posedge sys_clk) disable iff (sys_rst) width8 && par_valid);
   c_comp_rdy:  cover property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(compensation_ready));

endmodule : otdc_top

// *** verification/otdc_fabric_model.sv ***
// Fabric-side model driving the tap step, load and compensation controls.
`timescale 1ns/100ps
module otdc_fabric_model (
   // Clock.
   input  wire logic       sys_clk,
   // Controls toward the block.
   output logic            compensation_enable,
   output logic            step_req,
   output logic            step_dir,
   output logic            tap_load_strobe,
   output logic      [8:0] tap_load_bus,
   // Status from the block.
   input  wire logic       compensation_ready,
   input  wire logic [8:0] tap_readback_bus
);
   // Enable sits high through reset; commands idle low.
   initial begin
      compensation_enable = 1'b1;
      step_req = 1'b0;
      step_dir = 1'b0;
      tap_load_strobe = 1'b0;
      tap_load_bus = 9'h000;
   end
   // Ten quiet cycles on both sides so no change races compensation.
   task automatic set_comp(input logic en);
      repeat (10) @(posedge sys_clk);
      compensation_enable <= en;
      repeat (10) @(posedge sys_clk);
   endtask : set_comp
   // One tap per sampled cycle while the request is high.
   task automatic step(input int n, input logic dir);
      @(posedge sys_clk);
      step_req <= 1'b1;
      step_dir <= dir;
      repeat (n) @(posedge sys_clk);
      step_req <= 1'b0;
   endtask : step
   // Value first, then a one-cycle strobe; the bus is scrambled afterwards.
   task automatic load(input logic [8:0] v, input logic st);
      @(posedge sys_clk);
      tap_load_bus <= v;
      @(posedge sys_clk);
      tap_load_strobe <= 1'b1;
      step_req <= st;
      step_dir <= 1'b1;
      @(posedge sys_clk);
      tap_load_strobe <= 1'b0;
      step_req <= 1'b0;
      tap_load_bus <= ~v;
   endtask : load
   // Walk to a target in jumps of at most eight taps.
   task automatic load_to(input logic [8:0] target);
      logic [8:0] pos;
      while (compensation_ready !== 1'b1) @(posedge sys_clk);
      pos = tap_readback_bus;
      while (pos != target) begin
         if (target > pos) pos = (target - pos > 9'h008) ? pos + 9'h008 : target;
         else pos = (pos - target > 9'h008) ? pos - 9'h008 : target;
         load(pos, 1'b0);
      end
   endtask : load_to
endmodule : otdc_fabric_model

// *** verification/tb_top.sv ***
// Self-checking testbench for the output tap delay control.
`timescale 1ns/100ps
`include "otdc_map.svh"
module tb_top;
   logic        sys_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic        compensation_enable, step_req, step_dir, tap_load_strobe;
   logic        delay_ready, compensation_ready, pad_input, par_valid, strobe_fwd;
   logic [3:0]  wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [8:0]  tap_load_bus, tap_readback_bus, t0;
   logic [7:0]  par_q;
   int          n_fail, n_compared;
   otdc_top i_otdc_top (.sys_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .compensation_enable, .step_req,
      .step_dir, .tap_load_strobe, .tap_load_bus, .tap_readback_bus, .delay_ready,
      .compensation_ready, .pad_input, .par_q, .par_valid, .strobe_fwd);
   otdc_fabric_model i_otdc_fabric_model (.sys_clk, .compensation_enable, .step_req,
      .step_dir, .tap_load_strobe, .tap_load_bus, .compensation_ready, .tap_readback_bus);
   // 40 MHz clock.
   initial sys_clk = 1'b0;
   always #12.5 sys_clk = ~sys_clk;
   // Compare with case equality so an unknown never matches.
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // Classic single cycle; request held until ack is sampled high.
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      int k;
      @(posedge sys_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, 4'hF};
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 20);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      chk("ack", wb_ack_o, 1);
   endtask : wb
   // Tap settles one cycle after a command; two give margin.
   task automatic tap_is(input string what, input logic [8:0] exp);
      repeat (2) @(posedge sys_clk);
      chk(what, tap_readback_bus, exp);
   endtask : tap_is
   // Two received words so a mode change has flushed through.
   task automatic two_words();
      int k;
      repeat (2) begin
         k = 0;
         do @(posedge sys_clk); while (par_valid !== 1'b1 && k++ < 20);
      end
   endtask : two_words
   task automatic t_regs();
      chk("ready at reset", delay_ready, 0);
      wb(0, `OTDC_CFG_OFS, 0);
      chk("cfg reset", rd, `OTDC_CFG_RST);
      wb(0, `OTDC_RATIO_OFS, 0);
      chk("ratio reset", rd, `OTDC_RATIO_RST);
      wb(0, 4'h2, 0);
      chk("unmapped", rd, 0);
      while (compensation_ready !== 1'b1) @(posedge sys_clk);
      wb(0, `OTDC_STATUS_OFS, 0);
      chk("status ready", rd[11:10], 2'b11);
      i_otdc_fabric_model.set_comp(1'b0);
      $display("test regs done");
   endtask : t_regs
   task automatic t_fixed();
      wb(1, `OTDC_CFG_OFS, 32'h0000_0000);
      wb(1, `OTDC_VALUE_OFS, 32'h0000_01F5);
      tap_is("fixed base", 9'h1F5);
      i_otdc_fabric_model.step(2, 1'b1);
      i_otdc_fabric_model.load(9'h003, 1'b0);
      tap_is("fixed hold", 9'h1F5);
      $display("test fixed done");
   endtask : t_fixed
   task automatic t_var();
      wb(1, `OTDC_CFG_OFS, 32'h0000_0001);
      i_otdc_fabric_model.step(10, 1'b1);
      tap_is("step up", 9'h1FF);
      i_otdc_fabric_model.step(1, 1'b1);
      tap_is("wrap up", 9'h000);
      i_otdc_fabric_model.step(1, 1'b0);
      tap_is("wrap down", 9'h1FF);
      i_otdc_fabric_model.step(3, 1'b0);
      i_otdc_fabric_model.load(9'h007, 1'b0);
      tap_is("step down", 9'h1FC);
      $display("test variable done");
   endtask : t_var
   task automatic t_load();
      wb(1, `OTDC_CFG_OFS, 32'h0000_0002);
      i_otdc_fabric_model.load_to(9'h1EA);
      tap_is("load walk", 9'h1EA);
      i_otdc_fabric_model.load(9'h1EF, 1'b1);
      tap_is("load over step", 9'h1EF);
      i_otdc_fabric_model.step(2, 1'b1);
      tap_is("load mode step", 9'h1F1);
      $display("test load done");
   endtask : t_load
   task automatic t_comp();
      wb(1, `OTDC_VALUE_OFS, 32'h0000_03E8);
      wb(1, `OTDC_CFG_OFS, 32'h0000_0005);
      i_otdc_fabric_model.set_comp(1'b1);
      t0 = tap_readback_bus;
      wb(1, `OTDC_RATIO_OFS, 32'h0000_0066);
      tap_is("tracking", t0 + 9'd199);
      i_otdc_fabric_model.set_comp(1'b0);
      t0 = tap_readback_bus;
      wb(1, `OTDC_RATIO_OFS, 32'h0000_0033);
      tap_is("frozen", t0);
      $display("test compensation done");
   endtask : t_comp
   task automatic t_rx();
      pad_input <= 1'b1;
      wb(1, `OTDC_CFG_OFS, 32'h0000_0008);
      two_words();
      chk("width8 word", par_q, 8'hFF);
      wb(1, `OTDC_CFG_OFS, 32'h0000_0010);
      two_words();
      chk("width4 word", par_q, 8'h2F);
      chk("forward pos0", strobe_fwd, 1);
      wb(1, `OTDC_CFG_OFS, 32'h0000_0030);
      wb(0, `OTDC_STATUS_OFS, 0);
      chk("cfg error", rd[12], 1);
      chk("forward pos1", strobe_fwd, 0);
      $display("test receive done");
   endtask : t_rx
   task automatic summarize();
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : summarize
   // Reset, then the scenarios in order.
   initial begin
      {sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, pad_input} = 5'b10000;
      {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      n_fail = 0;
      n_compared = 0;
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      t_regs();
      t_fixed();
      t_var();
      t_load();
      t_comp();
      t_rx();
      summarize();
   end
   // The scenarios need a few hundred cycles; this is ample.
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      summarize();
   end
endmodule : tb_top
